// >>> boundary_compare.sv
// storage boundary comparator: flags accesses that cross the main/control line
// assumes: address and access kind come from same-clock logic
`timescale 1ns/1ns
`include "ext_fac_map.svh"
module boundary_compare (
	input wire logic clk,
	input wire logic nrst,
	bound_chk_if.cmp bc
);
	// ==========================================================================
	// compare: boundary is in 2K units of the address high bits
	wire [10:0] bnd_units = bc.boundary[10:0];
	wire [10:0] addr_units = bc.addr[15:5];
	wire        in_ctrl   = bnd_units <= addr_units;
	wire [7:0]  hi_byte   = bc.addr[15:8];
	// registered so the checks line up with the trap cycle
	always_ff @(posedge clk) begin
		if (!nrst) begin
			bc.addr_check <= 1'b0;
			bc.mach_check <= 1'b0;
		end else begin
			bc.addr_check <= (bc.access == ext_fac_pkg::ACC_MAIN) && in_ctrl;
			bc.mach_check <= (bc.access == ext_fac_pkg::ACC_CTRL) && !in_ctrl
				|| (bc.access == ext_fac_pkg::ACC_MAIN) && (bc.boundary[15:8] > hi_byte);
		end
	end
	a_main_chk: assert property (@(posedge clk) disable iff (!nrst)
		bc.access == ext_fac_pkg::ACC_MAIN && bc.boundary[10:0] <= bc.addr[15:5] |=> bc.addr_check)
		else $error("main access into control area not flagged");
	a_ctrl_chk: assert property (@(posedge clk) disable iff (!nrst)
		bc.access == ext_fac_pkg::ACC_CTRL && bc.boundary[10:0] > bc.addr[15:5] |=> bc.mach_check)
		else $error("control access into main area not flagged");
	a_idle: assert property (@(posedge clk) disable iff (!nrst)
		bc.access == ext_fac_pkg::ACC_NONE |=> !bc.addr_check && !bc.mach_check)
		else $error("check raised with no access");
	c_addr_chk: cover property (@(posedge clk) bc.addr_check);
	c_mach_chk: cover property (@(posedge clk) bc.mach_check);
endmodule : boundary_compare

// >>> ext_fac_if.sv
// carrier between the bank and its boundary comparator
// assumes: one clock domain
`timescale 1ns/1ns
interface bound_chk_if;
	logic [15:0]                boundary;
	logic [15:0]                addr;
	ext_fac_pkg::access_t       access;
	logic                       addr_check;
	logic                       mach_check;
	modport bank (output boundary, output addr, output access, input addr_check, input mach_check);
	modport cmp  (input boundary, input addr, input access, output addr_check, output mach_check);
endinterface : bound_chk_if

// >>> ext_fac_map.svh
// external facility register map: word addresses, field positions, storage size steps
// assumes: included by bare name from the design modules
`ifndef EXT_FAC_MAP_SVH
`define EXT_FAC_MAP_SVH
// ==========================================================================
// word addresses (six-bit external address) and the status select digit
`define ADDR_ZERO_SOURCE     6'h01
`define ADDR_FEATURE_CONFIG  6'h02
`define ADDR_SYSTEM_STATUS   6'h05
`define ADDR_MCHECK_B        6'h06
`define ADDR_MCHECK_A        6'h07
`define ADDR_PROC_MODE       6'h08
`define ADDR_BOUNDARY        6'h0A
`define ADDR_CONSOLE_SW      6'h0B
`define ADDR_PSW_CONTROL     6'h10
`define ADDR_MISC_LEVEL      6'h12
`define ADDR_INT_PENDING     6'h16
`define STATUS_DIGIT         4'hD
// ==========================================================================
// field masks, bit positions and storage size steps
`define MODE0_WMASK          8'h3F
`define INTERRUPT_MASK_A_WMASK           8'h07
`define CHANNEL_MASK_B_WMASK           8'h1F
`define EPSW_WMASK           8'h07
`define FEAT3_MASK           8'h63
`define BOUND_WMASK          16'h07FF
`define PSW_CONTROL_A_EXT_MASK_BIT   0
`define INTERRUPT_MASK_A_TIMER_BIT       7
`define INTERRUPT_MASK_A_EXTSIG_BIT      5
`define CS_STD_KB            32
`define CS_STEP_KB           2
`endif

// >>> ext_fac_pkg.sv
// types shared by the external facility bank
// assumes: encodings are written here, not taken from the map header
package ext_fac_pkg;
	typedef enum logic [1:0] {
		LOAD_SYS_RESET  = 2'b00,
		LOAD_POWER_ON   = 2'b01,
		LOAD_SUBSYSTEM  = 2'b10,
		LOAD_MULTIPROC  = 2'b11
	} load_type_t;
	typedef enum logic [1:0] {
		ACC_NONE = 2'b00,
		ACC_MAIN = 2'b01,
		ACC_CTRL = 2'b10
	} access_t;
endpackage : ext_fac_pkg

// >>> external_facility_registers.sv
// external facility word bank reached by microprogram word moves
// assumes: source/destination strobes and data come from the same-clock data flow
//
// How it works
// - zero source word reads all zero data with odd parity per byte
// - feature byte reports channel count minus one in two bits
// - mode byte 0 holds stop, enable, retry, recording, threshold controls
// - mode byte 2 shows least recently used adjust table register
// - mode byte 3 shows adjust table register matching pre-address
// - switch word bytes 0..3 are switch pairs one to four
// - psw byte 2 holds timer, interrupt, external masks; byte 3 channel masks
// - pending bit is on only when source pending and mask allows, except processor stop which is unmasked
// - interrupt bytes 0 and 1 bit assignment for sources
// - external pending needs source, master mask, and timer or signal mask
// - misc byte 3 and interrupt bytes 2,3 give wired serial digits
// - boundary register is two bytes splitting main and control storage
// - boundary register sits at address 0A, readable and writable
// - control boundary moves down in 2K steps past standard 32K
// - every storage access compares boundary against address register
// - main into control raises address check; control into main machine check
// - boundary at or below address checks; above high byte machine checks
// - boundary bit 5 selects internal or external sizes by bits 6-7; the code decodes no size select, bits 10:0 are compared as one value
// - system status word sits at address 05 and shows processor conditions
// - status byte 3 is the trap level register
// - status byte 2 two-bit field encodes last reset or load type
// - zero source moved into machine check word a clears both words
// - status word selected directly by digit D in a-source field
`timescale 1ns/1ns
`include "ext_fac_map.svh"
module external_facility_registers #(
	parameter logic [7:0]  EC_LEVEL      = 8'h00,   // arbitrary value
	parameter logic [7:0]  SERIAL_HEAD   = 8'h00,   // arbitrary value
	parameter logic [15:0] SERIAL_TAIL   = 16'h0000,// arbitrary value
	parameter int          CHANNELS      = 4
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// word move access
	input  wire logic [5:0]  addr,
	input  wire logic [3:0]  a_src_digit,
	input  wire logic        a_src_direct,
	input  wire logic        src_en,
	input  wire logic        dst_en,
	input  wire logic [3:0]  byte_sel,
	input  wire logic [31:0] wdata,
	input  wire logic        src_is_zero,
	output logic      [31:0] rdata,
	output logic      [3:0]  rparity,
	// features and console
	input  wire logic [3:0]  main_size,
	input  wire logic        file_adapter,
	input  wire logic        word_buffer,
	input  wire logic [7:0]  feat3,
	input  wire logic [31:0] console_sw,
	input  wire logic [7:0]  console_file_addr,
	input  wire logic [7:0]  lru_table_index,
	input  wire logic [7:0]  table_match,
	// interrupt sources
	input  wire logic        timer_src,
	input  wire logic [5:0]  external_signal_source,
	input  wire logic [1:0]  processor_signal_source,
	input  wire logic        sys_ctrl_src,
	input  wire logic        proc_stop_src,
	input  wire logic [4:0]  channel_src,
	// processor status and traps
	input  wire logic [7:0]  status0,
	input  wire logic [7:0]  status1,
	input  wire logic [1:0]  load_type,
	input  wire logic        load_type_we,
	input  wire logic [7:0]  trap_level,
	// storage check
	input  wire logic [15:0] storage_addr,
	input  wire logic        main_access,
	input  wire logic        ctrl_access,
	output logic             addr_check,
	output logic             mach_check,
	// machine check words and mode outputs
	input  wire logic [31:0] mcheck_set,
	output logic      [31:0] mcheck_a,
	output logic      [31:0] mcheck_b,
	output logic      [5:0]  mode_ctrl,
	output logic      [15:0] boundary,
	output logic      [1:0]  pending_any
);
	// ==========================================================================
	// elaboration check
	if (CHANNELS < 1 || CHANNELS > 4) begin : g_bad_channels
		$error("channel count out of range");
	end

	function automatic logic [3:0] odd_par(input logic [31:0] w);
		odd_par = {~^w[31:24], ~^w[23:16], ~^w[15:8], ~^w[7:0]};
	endfunction : odd_par

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		merge = {be[3] ? nw[31:24] : old[31:24], be[2] ? nw[23:16] : old[23:16],
			be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
	endfunction : merge

	// ==========================================================================
	// registers; byte 0 of a word is the high byte, bit 0 of a byte its lsb
	logic [7:0]  mode0_r;
	logic [7:0]  psw_control_a_r, psw_control_b_r, interrupt_mask_a_r, channel_mask_b_r;
	logic [15:0] bound_r;
	logic [1:0]  load_r;
	logic [31:0] mck_a_r, mck_b_r;

	// direct selection of the status word by digit D
	wire        sel_status = a_src_direct && (a_src_digit == `STATUS_DIGIT);
	wire [5:0]  eff_addr   = sel_status ? `ADDR_SYSTEM_STATUS : addr;
	wire        we         = dst_en && !src_en;
	wire [31:0] wval       = src_is_zero ? 32'h00000000 : wdata;

	// ==========================================================================
	// interrupt qualification
	wire        ext_master = psw_control_a_r[`PSW_CONTROL_A_EXT_MASK_BIT];
	wire        ext_pend   = ext_master && ((timer_src && interrupt_mask_a_r[`INTERRUPT_MASK_A_TIMER_BIT])
		|| ((|external_signal_source || |processor_signal_source) && interrupt_mask_a_r[`INTERRUPT_MASK_A_EXTSIG_BIT]));
	wire [7:0]  pending_bits_a = {2'b00, timer_src && ext_master && interrupt_mask_a_r[`INTERRUPT_MASK_A_TIMER_BIT],
		ext_pend, sys_ctrl_src && interrupt_mask_a_r[6],
		processor_signal_source & {2{ext_master && interrupt_mask_a_r[`INTERRUPT_MASK_A_EXTSIG_BIT]}},
		proc_stop_src};
	wire [7:0]  pending_bits_b = {channel_src & channel_mask_b_r[7:3], 3'b000};
	assign pending_any = {|pending_bits_a, |pending_bits_b};

	// ==========================================================================
	// feature configuration: channel count field
	wire [1:0]  chan_field = 2'(CHANNELS - 1);
	wire [7:0]  feat2 = {main_size, file_adapter, chan_field, word_buffer};

	// ==========================================================================
	// source words
	wire [31:0] w_feature = {16'h0000, feat2, feat3 & `FEAT3_MASK};
	wire [31:0] w_mode    = {mode0_r & `MODE0_WMASK << 2, console_file_addr,
		lru_table_index, table_match};
	wire [31:0] w_status  = {status0, status1, 4'h0, load_r, 2'b00, trap_level};
	wire [31:0] w_psw     = {psw_control_a_r, psw_control_b_r, interrupt_mask_a_r, channel_mask_b_r};
	wire [31:0] w_misc    = {2'b00, external_signal_source, 8'h00, EC_LEVEL, SERIAL_HEAD};
	wire [31:0] w_intr    = {pending_bits_a, pending_bits_b, SERIAL_TAIL};
	wire [31:0] w_bound   = {bound_r, 16'h0000};

	logic [31:0] rd_nxt;
	always_comb begin
		case (eff_addr)
			`ADDR_ZERO_SOURCE:    rd_nxt = 32'h00000000;
			`ADDR_FEATURE_CONFIG: rd_nxt = w_feature;
			`ADDR_SYSTEM_STATUS:  rd_nxt = w_status;
			`ADDR_MCHECK_B:       rd_nxt = mck_b_r;
			`ADDR_MCHECK_A:       rd_nxt = mck_a_r;
			`ADDR_PROC_MODE:      rd_nxt = w_mode;
			`ADDR_BOUNDARY:       rd_nxt = w_bound;
			`ADDR_CONSOLE_SW:     rd_nxt = console_sw;
			`ADDR_PSW_CONTROL:    rd_nxt = w_psw;
			`ADDR_MISC_LEVEL:     rd_nxt = w_misc;
			`ADDR_INT_PENDING:    rd_nxt = w_intr;
			default:              rd_nxt = 32'h00000000;
		endcase
	end

	// read data registered, parity odd per byte
	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdata   <= 32'h00000000;
			rparity <= 4'hF;
		end else if (src_en) begin
			rdata   <= rd_nxt & {{8{byte_sel[3]}}, {8{byte_sel[2]}}, {8{byte_sel[1]}}, {8{byte_sel[0]}}};
			rparity <= odd_par(rd_nxt & {{8{byte_sel[3]}}, {8{byte_sel[2]}}, {8{byte_sel[1]}}, {8{byte_sel[0]}}});
		end
	end

	// ==========================================================================
	// writable words
	wire wr_mode  = we && eff_addr == `ADDR_PROC_MODE;
	wire wr_psw   = we && eff_addr == `ADDR_PSW_CONTROL;
	wire wr_bound = we && eff_addr == `ADDR_BOUNDARY;
	wire wr_machine_check_word_a  = we && eff_addr == `ADDR_MCHECK_A;
	wire wr_machine_check_word_b  = we && eff_addr == `ADDR_MCHECK_B;
	wire clr_mck  = wr_machine_check_word_a && src_is_zero;
	// boundary bytes 0,1 merged as a word first, then cut to its two bytes
	wire [31:0] bound_merged = merge({bound_r, 16'h0000}, wval, byte_sel);

	// control words; reserved positions are masked so writes never reach them
	always_ff @(posedge clk) begin
		if (!nrst) begin
			mode0_r <= 8'h00;
			psw_control_a_r <= 8'h00;
			psw_control_b_r <= 8'h00;
			interrupt_mask_a_r  <= 8'h00;
			channel_mask_b_r  <= 8'h00;
			bound_r <= 16'h0000;
		end else begin
			if (wr_mode && byte_sel[3])
				mode0_r <= wval[31:24] & (`MODE0_WMASK << 2);
			if (wr_psw && byte_sel[3])
				psw_control_a_r <= wval[31:24] & `EPSW_WMASK;
			if (wr_psw && byte_sel[2])
				psw_control_b_r <= wval[23:16] & `EPSW_WMASK;
			if (wr_psw && byte_sel[1])
				interrupt_mask_a_r  <= wval[15:8] & (`INTERRUPT_MASK_A_WMASK << 5);
			if (wr_psw && byte_sel[0])
				channel_mask_b_r  <= wval[7:0] & (`CHANNEL_MASK_B_WMASK << 3);
			if (wr_bound)
				bound_r <= bound_merged[31:16] & `BOUND_WMASK;
		end
	end

	// machine check words: hardware sets win over a move in the same cycle
	always_ff @(posedge clk) begin
		if (!nrst) begin
			mck_a_r <= 32'h00000000;
			mck_b_r <= 32'h00000000;
			load_r  <= 2'b00;
		end else begin
			if (clr_mck) begin
				mck_a_r <= mcheck_set;
				mck_b_r <= 32'h00000000;
			end else begin
				mck_a_r <= (wr_machine_check_word_a ? merge(mck_a_r, wval, byte_sel) : mck_a_r) | mcheck_set;
				mck_b_r <= wr_machine_check_word_b ? merge(mck_b_r, wval, byte_sel) : mck_b_r;
			end
			if (load_type_we)
				load_r <= load_type;
		end
	end

	assign mcheck_a  = mck_a_r;
	assign mcheck_b  = mck_b_r;
	assign mode_ctrl = mode0_r[7:2];
	assign boundary  = bound_r;

	// ==========================================================================
	// boundary comparator
	bound_chk_if bc ();
	assign bc.boundary = bound_r;
	assign bc.addr     = storage_addr;
	assign bc.access   = main_access ? ext_fac_pkg::ACC_MAIN
		: (ctrl_access ? ext_fac_pkg::ACC_CTRL : ext_fac_pkg::ACC_NONE);
	assign addr_check  = bc.addr_check;
	assign mach_check  = bc.mach_check;

	boundary_compare u_cmp (
		.clk  (clk),
		.nrst (nrst),
		.bc   (bc.cmp)
	);

	// ==========================================================================
	// assertions
	property p_zero_read;
		@(posedge clk) disable iff (!nrst)
		src_en && !sel_status && addr == `ADDR_ZERO_SOURCE |=> rdata == 32'h00000000 && rparity == 4'hF;
	endproperty
	a_zero_read: assert property (p_zero_read) else $error("zero source not zero");

	property p_mck_clear;
		@(posedge clk) disable iff (!nrst)
		clr_mck && mcheck_set == 32'h00000000 |=> mck_a_r == 32'h00000000 && mck_b_r == 32'h00000000;
	endproperty
	a_mck_clear: assert property (p_mck_clear) else $error("machine check words not cleared");

	property p_ext_qual;
		@(posedge clk) disable iff (!nrst)
		pending_bits_a[4] |-> psw_control_a_r[`PSW_CONTROL_A_EXT_MASK_BIT] && (interrupt_mask_a_r[`INTERRUPT_MASK_A_TIMER_BIT] || interrupt_mask_a_r[`INTERRUPT_MASK_A_EXTSIG_BIT]);
	endproperty
	a_ext_qual: assert property (p_ext_qual) else $error("external pending without master mask");

	property p_chan_pend;
		@(posedge clk) disable iff (!nrst)
		pending_bits_b != 8'h00 |-> (channel_src & channel_mask_b_r[7:3]) != 5'b00000;
	endproperty
	a_chan_pend: assert property (p_chan_pend) else $error("channel pending without mask");

	property p_status_direct;
		@(posedge clk) disable iff (!nrst)
		src_en && sel_status && byte_sel == 4'hF |=> rdata[7:0] == $past(trap_level);
	endproperty
	a_status_direct: assert property (p_status_direct) else $error("status word not selected by digit");

	property p_bound_rw;
		@(posedge clk) disable iff (!nrst)
		wr_bound && byte_sel[3:2] == 2'b11 && !src_en ##1 !wr_bound
			##1 src_en && !sel_status && addr == `ADDR_BOUNDARY
			&& byte_sel[3:2] == 2'b11 |=> rdata[31:16] == (16'($past(wval[31:16], 3)) & `BOUND_WMASK);
	endproperty
	a_bound_rw: assert property (p_bound_rw) else $error("boundary readback mismatch");

	property p_reserved_mode;
		@(posedge clk) disable iff (!nrst)
		mode0_r[1:0] == 2'b00;
	endproperty
	a_reserved_mode: assert property (p_reserved_mode) else $error("reserved mode bits set");

	property p_load_type;
		@(posedge clk) disable iff (!nrst)
		load_type_we |=> load_r == $past(load_type);
	endproperty
	a_load_type: assert property (p_load_type) else $error("load type not captured");

	c_bound_write: cover property (@(posedge clk) wr_bound);
	c_mck_clear:   cover property (@(posedge clk) clr_mck);
	c_ext_pend:    cover property (@(posedge clk) pending_bits_a[4]);
endmodule : external_facility_registers

// >>> external_facility_registers_tb.sv
// testbench for the external facility word bank
// assumes: microprogram_model drives the word move bus and storage path
`timescale 1ns/1ns
module external_facility_registers_tb;
	// ==========================================================
	// signals and constants
	localparam logic [7:0]  EC   = 8'h27;     // arbitrary value
	localparam logic [7:0]  HEAD = 8'h3C;     // arbitrary value
	localparam logic [15:0] TAIL = 16'h9B4E;  // arbitrary value
	localparam logic [31:0] ALL  = 32'hFFFF_FFFF;
	// rows: boundary, address, main, ctrl, address check, machine check
	localparam logic [35:0] ROWS [10] = '{36'h01C2_3840_A, 36'h01C2_383F_8, 36'h01C2_0040_9,
		36'h01C2_0100_5, 36'h01C2_3840_4, 36'h01BA_3740_A, 36'h01BA_373F_8, 36'h01C2_3840_0,
		36'h0403_8060_A, 36'h0403_805F_8};
	logic        clk, nrst, src_en, dst_en, src_is_zero, a_src_direct, file_adapter, word_buffer;
	logic        timer_src, sys_ctrl_src, proc_stop_src, load_type_we, main_access, ctrl_access;
	logic        addr_check, mach_check;
	logic [1:0]  processor_signal_source, load_type, pending_any;
	logic [3:0]  a_src_digit, byte_sel, rparity, main_size;
	logic [4:0]  channel_src;
	logic [5:0]  addr, external_signal_source, mode_ctrl;
	logic [7:0]  feat3, console_file_addr, lru_table_index, table_match, status0, status1, trap_level;
	logic [15:0] storage_addr, boundary;
	logic [31:0] wdata, rdata, console_sw, mcheck_set, mcheck_a, mcheck_b, rd;
	int          fail_count = 0;
	int          n_checks = 0;
	int          cycles = 0;
	// ==========================================================
	// design, partner, clock, watchdog
	external_facility_registers #(.EC_LEVEL(EC), .SERIAL_HEAD(HEAD), .SERIAL_TAIL(TAIL), .CHANNELS(3)) dut_u (
		.clk(clk), .nrst(nrst), .addr(addr), .a_src_digit(a_src_digit), .a_src_direct(a_src_direct),
		.src_en(src_en), .dst_en(dst_en), .byte_sel(byte_sel), .wdata(wdata), .src_is_zero(src_is_zero),
		.rdata(rdata), .rparity(rparity), .main_size(main_size), .file_adapter(file_adapter),
		.word_buffer(word_buffer), .feat3(feat3), .console_sw(console_sw),
		.console_file_addr(console_file_addr), .lru_table_index(lru_table_index), .table_match(table_match),
		.timer_src(timer_src), .external_signal_source(external_signal_source),
		.processor_signal_source(processor_signal_source), .sys_ctrl_src(sys_ctrl_src),
		.proc_stop_src(proc_stop_src), .channel_src(channel_src), .status0(status0), .status1(status1),
		.load_type(load_type), .load_type_we(load_type_we), .trap_level(trap_level),
		.storage_addr(storage_addr), .main_access(main_access), .ctrl_access(ctrl_access),
		.addr_check(addr_check), .mach_check(mach_check), .mcheck_set(mcheck_set), .mcheck_a(mcheck_a),
		.mcheck_b(mcheck_b), .mode_ctrl(mode_ctrl), .boundary(boundary), .pending_any(pending_any));
	microprogram_model model_u (.clk(clk), .addr(addr), .a_src_digit(a_src_digit), .a_src_direct(a_src_direct),
		.src_en(src_en), .dst_en(dst_en), .byte_sel(byte_sel), .wdata(wdata), .src_is_zero(src_is_zero),
		.rdata(rdata), .storage_addr(storage_addr), .main_access(main_access), .ctrl_access(ctrl_access));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// a hang counts as a mismatch and still reaches the verdict
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			fail_count++;
			report_and_stop();
		end
	end
	// ==========================================================
	// shared helpers
	task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got, input logic [31:0] m);
		n_checks++;
		if ((got & m) !== (exp & m)) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp & m, got & m);
		end
	endtask : check32
	function automatic logic [3:0] oddpar(input logic [31:0] w);
		return {~^w[31:24], ~^w[23:16], ~^w[15:8], ~^w[7:0]};
	endfunction : oddpar
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	task automatic do_reset();
		@(negedge clk);
		nrst = 1'b0;
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		check32("boundary after reset", 32'h0, {16'h0, boundary}, ALL);
	endtask : do_reset
	// ==========================================================
	// scenarios
	task automatic t_boundary();
		model_u.fetch(6'h0A, 4'hF, 1'b0, rd);
		check32("boundary word at reset", 32'h0, rd, ALL);
		model_u.load_boundary();
		check32("boundary out", 32'h01C2, {16'h0, boundary}, ALL);
		model_u.fetch(6'h0A, 4'hF, 1'b0, rd);
		check32("boundary word", 32'h01C2_0000, rd, ALL);
		check32("boundary parity", {28'h0, oddpar(32'h01C2_0000)}, {28'h0, rparity}, ALL);
		model_u.move(6'h0A, 4'hF, ALL, 1'b0);
		model_u.fetch(6'h0A, 4'hF, 1'b0, rd);
		check32("boundary spare bits", 32'h07FF_0000, rd, ALL);
		do_reset();
		model_u.load_boundary();
		check32("boundary reload", 32'h01C2, {16'h0, boundary}, ALL);
	endtask : t_boundary
	task automatic t_compare();
		foreach (ROWS[i]) begin
			model_u.move(6'h0A, 4'hC, {ROWS[i][35:20], 16'h0}, 1'b0);
			model_u.access(ROWS[i][3], ROWS[i][2], ROWS[i][19:4]);
			check32("address check", {31'h0, ROWS[i][1]}, {31'h0, addr_check}, ALL);
			check32("machine check", {31'h0, ROWS[i][0]}, {31'h0, mach_check}, ALL);
		end
	endtask : t_compare
	task automatic t_words();
		model_u.move(6'h10, 4'hF, ALL, 1'b0);
		model_u.fetch(6'h10, 4'hF, 1'b0, rd);
		check32("psw control word", 32'h0707_E0F8, rd, ALL);
		model_u.move(6'h10, 4'h2, ALL, 1'b1);
		model_u.fetch(6'h10, 4'hF, 1'b0, rd);
		check32("zeroed psw byte", 32'h0707_00F8, rd, ALL);
		check32("psw parity", {28'h0, oddpar(32'h0707_00F8)}, {28'h0, rparity}, ALL);
		model_u.fetch(6'h01, 4'hF, 1'b0, rd);
		check32("zero source", {28'h0, 4'hF}, {rd[31:4], rparity}, ALL);
		model_u.fetch(6'h03, 4'hF, 1'b0, rd);
		check32("unmapped word", 32'h0, rd, ALL);
		model_u.move(6'h08, 4'hF, ALL, 1'b0);
		check32("mode controls", 32'h3F, {26'h0, mode_ctrl}, ALL);
		model_u.fetch(6'h08, 4'hF, 1'b0, rd);
		check32("mode word", {8'hFC, console_file_addr, lru_table_index, table_match}, rd, ALL);
		model_u.fetch(6'h0B, 4'hF, 1'b0, rd);
		check32("console switches", console_sw, rd, ALL);
		model_u.fetch(6'h02, 4'hF, 1'b0, rd);
		check32("feature bytes", 32'h0000_3563, rd, 32'h0000_FFFF);
		model_u.fetch(6'h12, 4'hF, 1'b0, rd);
		check32("misc level bytes", {16'h0, EC, HEAD}, rd, 32'h0000_FFFF);
	endtask : t_words
	task automatic t_irq();
		external_signal_source = 6'h01;
		timer_src = 1'b1;
		channel_src = 5'h1F;
		model_u.move(6'h10, 4'hF, 32'h0, 1'b0);
		model_u.fetch(6'h16, 4'hF, 1'b0, rd);
		check32("pending all masked", {16'h0, TAIL}, rd, ALL);
		check32("summary masked", 32'h0, {30'h0, pending_any}, ALL);
		model_u.move(6'h10, 4'hF, 32'h0100_0000, 1'b0);
		model_u.fetch(6'h16, 4'hF, 1'b0, rd);
		check32("master mask only", {16'h0, TAIL}, rd, ALL);
		{sys_ctrl_src, proc_stop_src, processor_signal_source} = 4'hF;
		model_u.move(6'h10, 4'hF, 32'h0300_E0F8, 1'b0);
		model_u.fetch(6'h16, 4'hF, 1'b0, rd);
		check32("pending all open", {16'h3FF8, TAIL}, rd, ALL);
		check32("summary open", 32'h3, {30'h0, pending_any}, ALL);
		model_u.move(6'h10, 4'hF, 32'h0200_E0F8, 1'b0);
		model_u.fetch(6'h16, 4'hF, 1'b0, rd);
		check32("master mask off", {16'h09F8, TAIL}, rd, ALL);
		{sys_ctrl_src, proc_stop_src, processor_signal_source} = 4'h0;
		external_signal_source = 6'h00;
		timer_src = 1'b0;
		channel_src = 5'h00;
	endtask : t_irq
	task automatic t_status();
		for (int t = 0; t < 4; t++) begin
			@(negedge clk);
			load_type = t[1:0];
			load_type_we = 1'b1;
			@(negedge clk);
			load_type_we = 1'b0;
			model_u.fetch(6'h08, 4'hF, 1'b1, rd);
			check32("status direct", {status0, status1, 4'h0, t[1:0], 2'h0, trap_level}, rd, 32'hFFFF_0CFF);
		end
		model_u.fetch(6'h05, 4'hF, 1'b0, rd);
		check32("status at 05", {status0, status1, 8'h0C, trap_level}, rd, 32'hFFFF_0CFF);
	endtask : t_status
	task automatic t_mcheck();
		@(negedge clk);
		mcheck_set = 32'h0000_8000;
		@(negedge clk);
		mcheck_set = 32'h0;
		check32("machine check set", 32'h8000, mcheck_a, 32'h8000);
		model_u.move(6'h06, 4'hF, 32'h0000_00FF, 1'b0);
		check32("machine check b write", 32'hFF, mcheck_b, ALL);
		model_u.move(6'h07, 4'hF, 32'h1234_5678, 1'b1);
		check32("machine check a cleared", 32'h0, mcheck_a, ALL);
		check32("machine check b cleared", 32'h0, mcheck_b, ALL);
	endtask : t_mcheck
	// ==========================================================
	// main sequence
	initial begin
		nrst = 1'b0;
		{file_adapter, sys_ctrl_src, proc_stop_src, load_type_we, timer_src} = 5'h00;
		word_buffer = 1'b1;
		main_size = 4'h3;
		feat3 = 8'hFF;
		console_sw = 32'h1122_3344;
		console_file_addr = 8'h5A;
		lru_table_index = 8'h81;
		table_match = 8'h24;
		external_signal_source = 6'h00;
		processor_signal_source = 2'h0;
		channel_src = 5'h00;
		status0 = 8'hA5;
		status1 = 8'h3C;
		trap_level = 8'hE1;
		load_type = 2'h0;
		mcheck_set = 32'h0;
		do_reset();
		t_boundary();
		t_compare();
		t_words();
		t_irq();
		t_status();
		t_mcheck();
		report_and_stop();
	end
endmodule : external_facility_registers_tb

// >>> microprogram_model.sv
// microprogram side model: word moves into the bank and storage accesses
// assumes: the bank takes requests on rising clk, so this model drives on falling clk
`timescale 1ns/1ns
module microprogram_model #(
	parameter logic [15:0] BOOT_BOUNDARY = 16'h01C2
) (
	// clock
	input  wire logic        clk,
	// word move bus
	output logic      [5:0]  addr,
	output logic      [3:0]  a_src_digit,
	output logic             a_src_direct,
	output logic             src_en,
	output logic             dst_en,
	output logic      [3:0]  byte_sel,
	output logic      [31:0] wdata,
	output logic             src_is_zero,
	input  wire logic [31:0] rdata,
	// storage path
	output logic      [15:0] storage_addr,
	output logic             main_access,
	output logic             ctrl_access
);
	// ==========================================================
	// idle bus
	initial begin
		addr         = 6'h00;
		a_src_digit  = 4'h0;
		a_src_direct = 1'b0;
		src_en       = 1'b0;
		dst_en       = 1'b0;
		byte_sel     = 4'h0;
		wdata        = 32'hA5A5_A5A5;
		src_is_zero  = 1'b0;
		storage_addr = 16'h0000;
		main_access  = 1'b0;
		ctrl_access  = 1'b0;
	end
	// ==========================================================
	// word move: one taking edge; data flips afterwards so stale data never looks fresh
	task automatic move(input logic [5:0] a, input logic [3:0] be, input logic [31:0] d, input logic z);
		@(negedge clk);
		addr        = a;
		byte_sel    = be;
		wdata       = d;
		src_is_zero = z;
		dst_en      = 1'b1;
		@(negedge clk);
		dst_en      = 1'b0;
		src_is_zero = 1'b0;
		wdata       = ~d;
	endtask : move
	// word read: answer is taken one and a half cycles after the request edge
	task automatic fetch(input logic [5:0] a, input logic [3:0] be, input logic dir, output logic [31:0] d);
		@(negedge clk);
		addr         = a;
		byte_sel     = be;
		a_src_direct = dir;
		a_src_digit  = dir ? 4'hD : 4'h0;
		src_en       = 1'b1;
		@(negedge clk);
		src_en       = 1'b0;
		a_src_direct = 1'b0;
		@(negedge clk);
		d = rdata;
	endtask : fetch
	// initial load and the system reset routine both write the configured boundary
	task automatic load_boundary();
		move(6'h0A, 4'hC, {BOOT_BOUNDARY, 16'h0000}, 1'b0);
	endtask : load_boundary
	// access held two edges so registered checks have settled when the caller looks
	task automatic access(input logic m, input logic c, input logic [15:0] sa);
		@(negedge clk);
		storage_addr = sa;
		main_access  = m;
		ctrl_access  = c;
		repeat (2) @(negedge clk);
		main_access  = 1'b0;
		ctrl_access  = 1'b0;
		storage_addr = ~sa;
	endtask : access
endmodule : microprogram_model
